// file: core/sgc_pkg.sv
/*
  sgc_pkg: register offsets, field positions, reset values and timing
  counts for the converter pin-output and conversion control block.
  Assumes a single 200 MHz clock and a plain strobe register port.
*/
package sgc_pkg;

  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned PIN_N    = 4;
  localparam int unsigned VALUE_W  = 10;
  localparam int unsigned INPUT_SELECT_W   = 3;

  // register offsets (word index on the register port)
  localparam logic [3:0] OFS_PIN_CTRL  = 4'h0; // analog_pin_output_control
  localparam logic [3:0] OFS_CONV_CTRL = 4'h1; // converter_control_reg
  localparam logic [3:0] OFS_RESULT    = 4'h2; // conversion_result_reg
  localparam logic [3:0] OFS_IRQ_STAT  = 4'h3; // sticky status, read only
  localparam logic [3:0] OFS_IRQ_ENA   = 4'h4; // interrupt enable
  localparam logic [3:0] OFS_IRQ_CLR   = 4'h5; // write one to clear

  // pin control field positions
  localparam int unsigned POS_LEVEL    = 0;   // levels 3..0
  localparam int unsigned POS_DRV_EN   = 4;   // driver enables 7..4
  localparam int unsigned POS_TIRQ_EN  = 8;
  localparam int unsigned POS_TDET     = 9;

  // converter control and result field positions
  localparam int unsigned POS_GO       = 15;
  localparam int unsigned POS_ACTIVE   = 15;
  localparam int unsigned POS_INPUT_SELECT     = 12;
  localparam int unsigned POS_VALUE    = 0;

  // interrupt status bits
  localparam int unsigned IRQ_DONE     = 0;
  localparam int unsigned IRQ_TOUCH    = 1;
  localparam int unsigned IRQ_N        = 2;

  localparam logic [15:0] PIN_CTRL_RST = 16'h0000;
  localparam logic [15:0] RESULT_RST   = 16'h0000;

  // conversion time: sample plus successive approximation steps
  localparam int unsigned CLK_MHZ      = 200;
  localparam int unsigned CONV_NS      = 6000;
  localparam int unsigned CONV_CYC     = (CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned STEP_NS      = 500;
  localparam int unsigned STEP_CYC     = (STEP_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {SGC_IDLE, SGC_RUN, SGC_DONE} sgc_state_t;

endpackage : sgc_pkg

// file: core/sgc_step_div.sv
/*
  sgc_step_div: free divider giving a one-cycle enable every DIV cycles
  while run is high; restarts when run drops. Assumes one clock.
*/
`timescale 1ns/1ps
module sgc_step_div
  import sgc_pkg::*;
#(
  parameter int unsigned DIV = STEP_CYC
)
(
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic run,
  output logic      stepPulse
);

  // refuse a divide that the 16-bit counter cannot serve
  if (DIV < 2 || DIV > 65535)
  begin : g_bad_div
    $error("sgc_step_div: DIV out of range");
  end

  logic [15:0] cnt_reg;
  wire         wrap = (cnt_reg == 16'(DIV - 1));

  // counter holds at zero outside a conversion to save toggling
  always_ff @(posedge mclk)
  begin
    if (sys_rst || !run)
      cnt_reg <= 16'h0000;
    else if (wrap)
      cnt_reg <= 16'h0000;
    else
      cnt_reg <= cnt_reg + 16'h0001;
  end

  assign stepPulse = run && wrap;

endmodule : sgc_step_div

// file: core/sgc_sar_core.sv
/*
  sgc_sar_core: successive-approximation search, one bit per step pulse,
  MSB first. Assumes the comparator input is synchronous to mclk.
*/
`timescale 1ns/1ps
module sgc_sar_core
  import sgc_pkg::*;
#(
  parameter int unsigned WIDTH = VALUE_W
)
(
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic             start,
  input  wire logic             step,
  input  wire logic             cmpAbove,
  output logic [WIDTH-1:0]      trial,
  output logic                  finished
);

  // refuse widths the result word cannot carry
  if (WIDTH < 2 || WIDTH > 16)
  begin : g_bad_width
    $error("sgc_sar_core: WIDTH out of range");
  end

  logic [WIDTH-1:0] bit_reg;
  logic [WIDTH-1:0] trial_reg;

  // keep the tried bit when the input is above the trial level
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      bit_reg   <= '0;
      trial_reg <= '0;
    end
    else if (start)
    begin
      bit_reg   <= {1'b1, {(WIDTH-1){1'b0}}};
      trial_reg <= {1'b1, {(WIDTH-1){1'b0}}};
    end
    else if (step && bit_reg != '0)
    begin
      bit_reg   <= bit_reg >> 1;
      trial_reg <= (cmpAbove ? trial_reg : (trial_reg & ~bit_reg))
                   | (bit_reg >> 1);
    end
  end

  assign trial    = trial_reg;
  assign finished = step && bit_reg == {{(WIDTH-1){1'b0}}, 1'b1};

endmodule : sgc_sar_core

// file: core/sgc_ctrl.sv
/*
  sgc_ctrl: analog pin output control, touch detect interrupt routing
  and single conversion handshake of the converter.
  Assumes a strobe register port synchronous to mclk, read data one
  cycle after the read strobe, and a comparator input from the analog
  macro that is synchronous to mclk.
*/
//
// What this block does
// RULE1: driver enable bits 7..4 turn each pin driver on; off keeps analog.
// RULE2: level bits 3..0 drive each pin high or low while it outputs.
// RULE3: status bit 9 reads one while touch is detected.
// RULE4: bit 8 routes the touch detect onto the converter interrupt.
// RULE5: touch interrupt term is high only when detect and enable both one.
// RULE6: software sets go and writes the input number to start.
// RULE7: busy flag reads one while a conversion is under way.
// RULE8: at the end both go and busy return to zero.
// RULE9: afterwards the converter idles in standby until the next go.
// RULE10: after busy falls result holds converted input and value.
// RULE11: software should read back busy before waiting on completion.
// RULE12: software should keep the converter clock at or below 2MHz.
`timescale 1ns/1ps
module sgc_ctrl
  import sgc_pkg::*;
#(
  parameter int unsigned STEP_DIV = STEP_CYC
)
(
  input  wire logic                mclk,
  input  wire logic                sys_rst,
  input  wire logic [ADDR_W-1:0]   regAddr,
  input  wire logic [DATA_W-1:0]   regWdata,
  input  wire logic                regWrite,
  input  wire logic                regRead,
  output logic      [DATA_W-1:0]   regRdata,
  input  wire logic                touchDetectIn,
  input  wire logic                cmpAbove,
  output logic      [PIN_N-1:0]    pinOut,
  output logic      [PIN_N-1:0]    pinOe,
  output logic      [INPUT_SELECT_W-1:0]   muxSelect,
  output logic                     sampleEnable,
  output logic                     converterStandby,
  output logic                     irqOut
);

  // a divide below two would give a step on every cycle
  if (STEP_DIV < 2)
  begin : g_bad_div
    $error("sgc_ctrl: STEP_DIV too small");
  end

  // ---------------------------------------------------------------
  // state
  logic [7:0]          pinCfg_reg;      // enables 7..4, levels 3..0
  logic                touchEn_reg;
  logic                touchDet_reg;
  logic                go_reg;
  logic                active_reg;
  logic [INPUT_SELECT_W-1:0]   input_select_reg;
  logic [VALUE_W-1:0]  value_reg;
  logic [IRQ_N-1:0]    irqStat_reg;
  logic [IRQ_N-1:0]    irqEna_reg;
  logic [DATA_W-1:0]   rdata_reg;
  logic [PIN_N-1:0]    pinOut_reg;
  logic [PIN_N-1:0]    pinOe_reg;
  logic                irq_reg;
  logic                samp_reg;
  logic                standby_reg;
  sgc_state_t          state_reg;
  sgc_state_t          state_next;

  // ---------------------------------------------------------------
  // address decode
  wire wrPin   = regWrite && regAddr == OFS_PIN_CTRL;
  wire wrConv  = regWrite && regAddr == OFS_CONV_CTRL;
  wire wrRes   = regWrite && regAddr == OFS_RESULT;
  wire wrIrqEn = regWrite && regAddr == OFS_IRQ_ENA;
  wire wrIrqCl = regWrite && regAddr == OFS_IRQ_CLR;

  // a start needs the go bit; a go while busy is ignored
  wire startReq = wrConv && regWdata[POS_GO] && state_reg == SGC_IDLE;

  // ---------------------------------------------------------------
  // search engine
  wire                 stepPulse;
  wire                 convFinished;
  wire [VALUE_W-1:0]   trialValue;

  sgc_step_div #(
    .DIV       (STEP_DIV)
  ) u_div (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .run       (state_reg == SGC_RUN),
    .stepPulse (stepPulse)
  );

  sgc_sar_core #(
    .WIDTH     (VALUE_W)
  ) u_sar (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .start     (startReq),
    .step      (stepPulse),
    .cmpAbove  (cmpAbove),
    .trial     (trialValue),
    .finished  (convFinished)
  );

  // ---------------------------------------------------------------
  // conversion sequence
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      SGC_IDLE: if (startReq) state_next = SGC_RUN;        // see RULE7
      SGC_RUN:  if (convFinished) state_next = SGC_DONE;
      SGC_DONE: state_next = SGC_IDLE;                     // see RULE9
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      state_reg <= SGC_IDLE;
    else
      state_reg <= state_next;
  end

  // go and busy rise together and fall together at completion
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      go_reg     <= 1'b0;
      active_reg <= 1'b0;
    end
    else if (startReq)
    begin
      go_reg     <= 1'b1;                                  // see RULE7
      active_reg <= 1'b1;                                  // see RULE7
    end
    else if (state_reg == SGC_RUN && convFinished)
    begin
      go_reg     <= 1'b0;                                  // see RULE8
      active_reg <= 1'b0;                                  // see RULE8
    end
  end

  // channel is written by software; frozen while busy so it stays valid
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      input_select_reg <= '0;
    else if (wrRes && !active_reg)
      input_select_reg <= regWdata[POS_INPUT_SELECT +: INPUT_SELECT_W];
  end

  // the value lands in the same edge that busy falls
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      value_reg <= '0;
    else if (state_reg == SGC_RUN && convFinished)
      value_reg <= {trialValue[VALUE_W-1:1], cmpAbove};   // see RULE10
  end

  // ---------------------------------------------------------------
  // pin and touch control
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      pinCfg_reg  <= PIN_CTRL_RST[7:0];
      touchEn_reg <= PIN_CTRL_RST[POS_TIRQ_EN];
    end
    else if (wrPin)
    begin
      pinCfg_reg  <= regWdata[7:0];
      touchEn_reg <= regWdata[POS_TIRQ_EN];
    end
  end

  // detect mirrors the pen comparator; it is a level, not latched
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      touchDet_reg <= 1'b0;
    else
      touchDet_reg <= touchDetectIn;                       // see RULE3
  end

  // low level pins stay enabled: the driver grounds them
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      pinOe_reg  <= '0;
      pinOut_reg <= '0;
    end
    else
    begin
      pinOe_reg  <= pinCfg_reg[POS_DRV_EN +: PIN_N];      // see RULE1
      pinOut_reg <= pinCfg_reg[POS_LEVEL +: PIN_N]
                    & pinCfg_reg[POS_DRV_EN +: PIN_N];    // see RULE2
    end
  end

  // ---------------------------------------------------------------
  // interrupts: set wins over a clear in the same cycle
  wire [IRQ_N-1:0] irqSet;
  assign irqSet[IRQ_DONE]  = state_reg == SGC_RUN && convFinished;
  assign irqSet[IRQ_TOUCH] = touchDet_reg && touchEn_reg;  // see RULE5

  wire [IRQ_N-1:0] irqClr = wrIrqCl ? regWdata[IRQ_N-1:0] : '0;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      irqStat_reg <= '0;
      irqEna_reg  <= '0;
    end
    else
    begin
      irqStat_reg <= (irqStat_reg & ~irqClr) | irqSet;
      if (wrIrqEn)
        irqEna_reg <= regWdata[IRQ_N-1:0];
    end
  end

  // touch term routed straight, not through the sticky path
  wire touchIrq = touchDet_reg && touchEn_reg;             // see RULE4
  wire irqNext  = |(irqStat_reg & irqEna_reg) | touchIrq;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      irq_reg <= 1'b0;
    else
      irq_reg <= irqNext;
  end

  // ---------------------------------------------------------------
  // read mux
  wire [DATA_W-1:0] pinWord =
    DATA_W'({touchDet_reg, touchEn_reg, pinCfg_reg});
  wire [DATA_W-1:0] convWord = DATA_W'({go_reg, 15'h0000});
  wire [DATA_W-1:0] resWord  =
    {active_reg, input_select_reg, 2'h0, value_reg};
  wire [DATA_W-1:0] rdSel =
    (regAddr == OFS_PIN_CTRL)  ? pinWord :
    (regAddr == OFS_CONV_CTRL) ? convWord :
    (regAddr == OFS_RESULT)    ? resWord :
    (regAddr == OFS_IRQ_STAT)  ? DATA_W'(irqStat_reg) :
    (regAddr == OFS_IRQ_ENA)   ? DATA_W'(irqEna_reg) :
                                 16'h0000;

  // data stands for exactly one cycle after the read strobe
  always_ff @(posedge mclk)
  begin
    if (sys_rst || !regRead)
      rdata_reg <= 16'h0000;
    else
      rdata_reg <= rdSel;
  end

  // standby has its own flop so the output carries no inverter glitch
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      samp_reg    <= 1'b0;
      standby_reg <= 1'b1;
    end
    else
    begin
      samp_reg    <= state_next == SGC_RUN;
      standby_reg <= state_next != SGC_RUN;                // see RULE9
    end
  end

  assign regRdata         = rdata_reg;
  assign pinOut           = pinOut_reg;
  assign pinOe            = pinOe_reg;
  assign muxSelect        = input_select_reg;
  assign sampleEnable     = samp_reg;
  assign converterStandby = standby_reg;                   // see RULE9
  assign irqOut           = irq_reg;

  // ---------------------------------------------------------------
  // assertions
  a_drive_enable: assert property (                      // see RULE1
    @(posedge mclk) disable iff (sys_rst)
    wrPin |=> ##1 pinOe == $past(regWdata[7:4], 2))
    else $error("driver enable does not follow pin control");
  a_pin_level: assert property (                         // see RULE2
    @(posedge mclk) disable iff (sys_rst)
    wrPin |=> ##1 pinOut == ($past(regWdata[3:0], 2)
      & $past(regWdata[7:4], 2)))
    else $error("pin level does not follow pin control");
  a_pin_quiet: assert property (                         // see RULE2
    @(posedge mclk) disable iff (sys_rst)
    (pinOut & ~pinOe) == '0)
    else $error("level shown on a pin that is not driven");
  a_touch_status: assert property (                      // see RULE3
    @(posedge mclk) disable iff (sys_rst)
    touchDet_reg == $past(touchDetectIn))
    else $error("touch status lost");
  a_touch_route: assert property (                       // see RULE4
    @(posedge mclk) disable iff (sys_rst)
    touchDet_reg && touchEn_reg |=> irqOut)
    else $error("enabled touch not on interrupt");
  a_touch_gate: assert property (                        // see RULE5
    @(posedge mclk) disable iff (sys_rst)
    !touchEn_reg && irqEna_reg == '0 |=> !irqOut)
    else $error("interrupt without enable");
  a_busy_start: assert property (                        // see RULE7
    @(posedge mclk) disable iff (sys_rst)
    startReq |=> active_reg && go_reg)
    else $error("busy not set at start");
  a_busy_level: assert property (                        // see RULE7
    @(posedge mclk) disable iff (sys_rst)
    state_reg == SGC_RUN |-> active_reg && go_reg && sampleEnable)
    else $error("busy or sampling low during a conversion");
  a_busy_end: assert property (                          // see RULE8
    @(posedge mclk) disable iff (sys_rst)
    $fell(active_reg) |-> !go_reg && state_reg == SGC_DONE)
    else $error("go and busy not cleared together");
  a_standby: assert property (                           // see RULE9
    @(posedge mclk) disable iff (sys_rst)
    state_reg == SGC_DONE |=> converterStandby
      ##1 (converterStandby || $past(startReq)))
    else $error("converter not in standby after end");
  a_result_hold: assert property (                       // see RULE10
    @(posedge mclk) disable iff (sys_rst)
    !active_reg && !startReq && !wrRes |=> $stable(resWord))
    else $error("result changed while idle");
  a_input_select_hold: assert property (                         // see RULE10
    @(posedge mclk) disable iff (sys_rst)
    active_reg |=> $stable(muxSelect))
    else $error("input select moved during a conversion");

  c_conversion: cover property (@(posedge mclk) disable iff (sys_rst)
    $rose(active_reg) ##[1:1000] $fell(active_reg));
  c_touch_irq: cover property (@(posedge mclk) disable iff (sys_rst)
    touchEn_reg && $rose(touchDet_reg));
  c_set_clear: cover property (@(posedge mclk) disable iff (sys_rst)
    wrIrqCl && |(irqClr & irqSet));
  c_pin_out: cover property (@(posedge mclk) disable iff (sys_rst)
    pinOe == 4'hf && pinOut == 4'h5);

endmodule : sgc_ctrl

// file: verif/tb_top.sv
/*
  tb_top: self-checking bench for sgc_ctrl, covering pin drivers, touch
  interrupt routing, the conversion handshake and the interrupt registers.
  Assumes the register port timing and the map given in sgc_pkg.
*/
`timescale 1ns/1ps
module tb_top
  import sgc_pkg::*;
;
  localparam int unsigned DIV = STEP_CYC; // 2 MHz steps

  logic                mclk;
  logic                sys_rst;
  logic [ADDR_W-1:0]   regAddr;
  logic [DATA_W-1:0]   regWdata;
  logic                regWrite;
  logic                regRead;
  logic [DATA_W-1:0]   regRdata;
  logic                touchDetectIn;
  logic                cmpAbove;
  logic [PIN_N-1:0]    pinOut;
  logic [PIN_N-1:0]    pinOe;
  logic [INPUT_SELECT_W-1:0]   muxSelect;
  logic                sampleEnable;
  logic                converterStandby;
  logic                irqOut;
  logic [15:0]         rv;
  int                  fail_count;
  int                  num_checks;

  sgc_ctrl #(.STEP_DIV(DIV)) uut (
    .mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .touchDetectIn(touchDetectIn),
    .cmpAbove(cmpAbove), .pinOut(pinOut), .pinOe(pinOe),
    .muxSelect(muxSelect), .sampleEnable(sampleEnable),
    .converterStandby(converterStandby), .irqOut(irqOut)
  );

  // free-running 200 MHz clock
  always #2.5 mclk = ~mclk;

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  // one-cycle write; a spare edge keeps each strobe assigned once a step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
    @(posedge mclk);
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 rv = regRdata;
    @(posedge mclk);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : settle

  task automatic t_reset;
    rd(OFS_PIN_CTRL);
    chk("pin ctrl reset", PIN_CTRL_RST, rv);
    rd(OFS_RESULT);
    chk("result reset", RESULT_RST, rv);
    chk("outputs reset", 16'h0001, {pinOe, pinOut, 7'h00, converterStandby});
    rd(4'h7);
    chk("unmapped read", 16'h0000, rv);
  endtask : t_reset

  task automatic t_pins;
    logic [15:0] pat [3] = '{16'h00f5, 16'h00a3, 16'h005c};
    foreach (pat[i])
    begin
      wr(OFS_PIN_CTRL, pat[i]);
      settle(1);
      chk("pin enable", {12'h000, pat[i][7:4]}, {12'h000, pinOe});
      chk("pin level", {12'h000, pat[i][3:0] & pat[i][7:4]},
          {12'h000, pinOut});
      rd(OFS_PIN_CTRL);
      chk("pin readback", pat[i], rv);
    end
    wr(4'h9, 16'hffff);
    rd(OFS_PIN_CTRL);
    chk("unmapped write", 16'h005c, rv);
    wr(OFS_PIN_CTRL, 16'h0000);
  endtask : t_pins

  // touch detect visible in status, routed only while enabled
  task automatic t_touch;
    touchDetectIn <= 1'b1;
    settle(3);
    rd(OFS_PIN_CTRL);
    chk("touch status", 16'h0200, rv);
    chk("irq masked", 16'h0000, {15'h0000, irqOut});
    wr(OFS_PIN_CTRL, 16'h0100);
    settle(2);
    chk("irq routed", 16'h0001, {15'h0000, irqOut});
    touchDetectIn <= 1'b0;
    settle(3);
    chk("irq drop", 16'h0000, {15'h0000, irqOut});
    rd(OFS_PIN_CTRL);
    chk("touch gone", 16'h0100, rv);
    rd(OFS_IRQ_STAT);
    chk("touch sticky", 16'h0002, rv);
    wr(OFS_IRQ_CLR, 16'h0002);
    rd(OFS_IRQ_STAT);
    chk("touch cleared", 16'h0000, rv);
    wr(OFS_PIN_CTRL, 16'h0000);
  endtask : t_touch

  // single conversion; comparator level fixes the expected value
  task automatic t_conv(input logic [2:0] ch, input logic cmp);
    int n;
    cmpAbove <= cmp;
    wr(OFS_RESULT, {1'b0, ch, 12'h000});
    wr(OFS_CONV_CTRL, 16'h8000);
    rd(OFS_RESULT);
    chk("busy set", {1'b1, ch, 12'h000}, {rv[15:12], 12'h000});
    chk("running", {12'h000, 1'b1, ch}, {12'h000, sampleEnable, muxSelect});
    wr(OFS_RESULT, {1'b0, ~ch, 12'h000});
    chk("input_select held", {13'h0000, ch}, {13'h0000, muxSelect});
    n = 0;
    while (rv[15] !== 1'b0 && n < 1000)
    begin
      rd(OFS_RESULT);
      n++;
    end
    if (rv[15] !== 1'b0)
    begin
      fail_count++;
      $display("BAD conversion end expected done seen busy");
      wrap_up();
    end
    chk("result", {1'b0, ch, 2'b00, {10{cmp}}}, rv);
    rd(OFS_CONV_CTRL);
    chk("go cleared", 16'h0000, rv & 16'h8000);
    settle(20);
    chk("standby", 16'h0001,
        {14'h0000, sampleEnable, converterStandby});
  endtask : t_conv

  // done event: raised, masked, enabled and cleared
  task automatic t_done_irq;
    t_conv(3'h5, 1'b1);
    chk("done masked", 16'h0000, {15'h0000, irqOut});
    rd(OFS_IRQ_STAT);
    chk("done status", 16'h0001, rv);
    wr(OFS_IRQ_ENA, 16'h0001);
    settle(1);
    chk("done irq", 16'h0001, {15'h0000, irqOut});
    wr(OFS_IRQ_CLR, 16'h0001);
    settle(1);
    chk("done clear", 16'h0000, {15'h0000, irqOut});
    t_conv(3'h2, 1'b0);
    chk("done again", 16'h0001, {15'h0000, irqOut});
    wr(OFS_IRQ_CLR, 16'h0001);
    rd(OFS_IRQ_STAT);
    chk("status clear", 16'h0000, rv);
  endtask : t_done_irq

  // reset for 10 cycles, then each scenario in turn
  initial
  begin
    mclk          = 1'b0;
    sys_rst       = 1'b1;
    regAddr       = 4'h0;
    regWdata      = 16'h0000;
    regWrite      = 1'b0;
    regRead       = 1'b0;
    touchDetectIn = 1'b0;
    cmpAbove      = 1'b0;
    fail_count    = 0;
    num_checks    = 0;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_pins();
    t_touch();
    t_done_irq();
    t_conv(3'h7, 1'b1);
    wrap_up();
  end
endmodule : tb_top
